// ---- src/otp_burn_pkg.sv ----
package otp_burn_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned BURN_TIME_MS = 10;
    localparam int unsigned REFRESH_TIME_MS = 5;
    localparam int unsigned BURN_CYCLES = CLK_HZ / 1000 * BURN_TIME_MS;
    localparam int unsigned REFRESH_CYCLES = CLK_HZ / 1000 * REFRESH_TIME_MS;

    localparam int unsigned MEM_BYTES = 32;
    localparam int unsigned SIG_FIRST = 2;
    localparam int unsigned SIG_COUNT = 28;
    localparam logic [7:0] SIG_POLY = 8'h1d;

    localparam logic [7:0] ADDR_SIGNATURE = 8'h1e;
    localparam logic [7:0] ADDR_CTRL = 8'h23;
    localparam logic [7:0] ADDR_KEY1 = 8'h62;
    localparam logic [7:0] ADDR_KEY2 = 8'h63;
    localparam logic [7:0] ADDR_ANGLE_LO = 8'h24;
    localparam logic [7:0] ADDR_ANGLE_HI = 8'h25;
    localparam logic [7:0] ADDR_STATUS = 8'h26;
    localparam logic [7:0] ADDR_SIG_CALC = 8'h27;
    localparam logic [7:0] ADDR_LOCK = 8'h1d;

    localparam logic [7:0] CTRL_DSP_RESET = 8'h20;
    localparam logic [7:0] CTRL_GUARD = 8'h40;
    localparam logic [7:0] CTRL_NORMAL = 8'h00;
    localparam logic [7:0] KEY1_VAL = 8'h70;
    localparam logic [7:0] KEY2_VAL = 8'h51;
    localparam int unsigned LOCK_BIT = 0;

    localparam int unsigned ST_COMM = 0;
    localparam int unsigned ST_BUSY = 1;
    localparam int unsigned ST_GUARD = 2;
    localparam int unsigned ST_BURNED = 3;
    localparam int unsigned ST_SIG_OK = 4;

    typedef enum {S_IDLE, S_BURN, S_REFRESH} phase_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [7:0] dat;
    } wb_req_s;

endpackage : otp_burn_pkg

// ---- src/otp_signature_burn_verify.sv ----
module otp_signature_burn_verify
    import otp_burn_pkg::*;
#(
    parameter int unsigned BURN_CYC = BURN_CYCLES,
    parameter int unsigned REFRESH_CYC = REFRESH_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] angle_i,
    output logic dsp_reset_o,
    output logic guard_band_o,
    output logic functional_mode_o
);

    //////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic ack;
        logic [7:0] rdat;
        logic key_armed;
        phase_e phase;
        logic [23:0] timer;
        logic guard;
        logic dsp_rst;
        logic burned;
        logic func_mode;
        logic [15:0] angle_s1;
        logic [15:0] angle_s2;
    } top_s;

    top_s st_ff;
    top_s nxt_st;
    logic [7:0] shadow_ff [MEM_BYTES];
    // unburned fuses read as zero
    logic [7:0] fuse_ff [MEM_BYTES] = '{default: 8'h00};
    logic [7:0] rd_sel;
    logic misr_start;
    logic [4:0] misr_idx;
    logic misr_busy;
    logic [7:0] misr_sig;
    wb_req_s req;
    logic wr_go;
    logic rd_go;
    logic in_mem;

    //////////////////////////////////////////////////////////////////////
    // bus decode

    always_comb begin
        req.cyc = wb_cyc_i;
        req.stb = wb_stb_i;
        req.we = wb_we_i;
        req.adr = wb_adr_i;
        req.dat = wb_dat_i;
    end

    assign wr_go = req.cyc && req.stb && req.we && !st_ff.ack && wb_sel_i[0];
    assign rd_go = req.cyc && req.stb && !req.we && !st_ff.ack;
    assign in_mem = req.adr < 8'(MEM_BYTES);

    always_comb begin
        rd_sel = 8'h00;
        if (in_mem) begin
            rd_sel = shadow_ff[req.adr[4:0]];
        end else begin
            unique case (req.adr)
                ADDR_ANGLE_LO: rd_sel = st_ff.angle_s2[7:0];
                ADDR_ANGLE_HI: rd_sel = st_ff.angle_s2[15:8];
                ADDR_STATUS: begin
                    rd_sel[ST_COMM] = !st_ff.func_mode;
                    rd_sel[ST_BUSY] = st_ff.phase != S_IDLE;
                    rd_sel[ST_GUARD] = st_ff.guard;
                    rd_sel[ST_BURNED] = st_ff.burned;
                    rd_sel[ST_SIG_OK] = shadow_ff[ADDR_SIGNATURE[4:0]] == misr_sig;
                end
                ADDR_SIG_CALC: rd_sel = misr_sig;
                default: rd_sel = 8'h00;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////
    // control

    always_comb begin
        nxt_st = st_ff;
        nxt_st.angle_s1 = angle_i;
        nxt_st.angle_s2 = st_ff.angle_s1;
        nxt_st.ack = (req.cyc && req.stb) && !st_ff.ack;
        nxt_st.dsp_rst = 1'b0;
        misr_start = 1'b0;
        if (rd_go) begin
            nxt_st.rdat = rd_sel;
        end
        if (wr_go) begin
            nxt_st.key_armed = 1'b0;
            if (req.adr == ADDR_CTRL) begin
                if (req.dat == CTRL_DSP_RESET) begin
                    nxt_st.dsp_rst = 1'b1;
                end else if (req.dat == CTRL_GUARD || req.dat == CTRL_NORMAL) begin
                    nxt_st.guard = req.dat == CTRL_GUARD;
                    nxt_st.phase = S_REFRESH;
                    nxt_st.timer = 24'(REFRESH_CYC);
                end
            end else if (req.adr == ADDR_KEY1 && req.dat == KEY1_VAL) begin
                nxt_st.key_armed = !st_ff.func_mode;
            end else if (req.adr == ADDR_KEY2 && req.dat == KEY2_VAL && st_ff.key_armed) begin
                nxt_st.phase = S_BURN;
                nxt_st.timer = 24'(BURN_CYC);
                misr_start = 1'b1;
            end
        end
        if (st_ff.phase != S_IDLE) begin
            nxt_st.timer = st_ff.timer - 24'h000001;
            if (st_ff.timer == 24'h000001) begin
                nxt_st.phase = S_IDLE;
                if (st_ff.phase == S_BURN) begin
                    nxt_st.burned = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.phase <= S_IDLE;
            // power-on mode follows the fused lock bit
            st_ff.func_mode <= fuse_ff[ADDR_LOCK[4:0]][LOCK_BIT];
        end else begin
            st_ff <= nxt_st;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // memories

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < MEM_BYTES; i++) begin
            if (st_ff.phase == S_BURN && st_ff.timer == 24'h000001) begin
                fuse_ff[i] <= fuse_ff[i] | shadow_ff[i];
            end
            if (rst_i || (st_ff.phase == S_REFRESH && st_ff.timer == 24'h000001)) begin
                shadow_ff[i] <= fuse_ff[i];
            end else if (wr_go && in_mem && st_ff.phase == S_IDLE && req.adr[4:0] == 5'(i)) begin
                shadow_ff[i] <= req.dat;
            end
        end
    end

    signature_misr u_misr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(misr_start),
        .byte_i(shadow_ff[5'(SIG_FIRST) + misr_idx]),
        .index_o(misr_idx),
        .busy_o(misr_busy),
        .sig_o(misr_sig)
    );

    assign functional_mode_o = st_ff.func_mode;
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.rdat;
    assign dsp_reset_o = st_ff.dsp_rst;
    assign guard_band_o = st_ff.guard;

endmodule : otp_signature_burn_verify

// ---- src/signature_misr.sv ----
module signature_misr
    import otp_burn_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] byte_i,
    output logic [4:0] index_o,
    output logic busy_o,
    output logic [7:0] sig_o
);

    typedef struct packed {
        logic busy;
        logic [4:0] idx;
        logic [7:0] misr;
    } misr_s;

    misr_s st_ff;
    misr_s nxt_st;
    logic [7:0] step;

    always_comb begin
        nxt_st = st_ff;
        step = {st_ff.misr[6:0], 1'b0} ^ byte_i;
        if (st_ff.misr[7]) begin
            step = step ^ SIG_POLY;
        end
        if (start_i) begin
            nxt_st.busy = 1'b1;
            nxt_st.idx = '0;
            nxt_st.misr = '0;
        end else if (st_ff.busy) begin
            nxt_st.misr = step;
            nxt_st.idx = st_ff.idx + 5'h01;
            if (st_ff.idx == 5'(SIG_COUNT - 1)) begin
                nxt_st.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign index_o = st_ff.idx;
    assign busy_o = st_ff.busy;
    assign sig_o = st_ff.misr;

endmodule : signature_misr

// ---- tb/magnet_model.sv ----
module magnet_model #(
    parameter logic [15:0] POS_A = 16'h0000,
    parameter logic [15:0] POS_B = 16'hffff
) (
    input wire logic clk_i,
    input wire logic stop_i,
    output logic [15:0] angle_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // magnet at start or stop position
    always_ff @(posedge clk_i) begin
        angle_o <= stop_i ? POS_B : POS_A;
    end
endmodule : magnet_model

// ---- tb/otp_signature_burn_verify_bench.sv ----
module otp_signature_burn_verify_bench
    import otp_burn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned CN = 20;
    localparam logic [15:0] PA = 16'h1234;
    localparam logic [15:0] PB = 16'h0abc;
    logic clk_i, rst_i, cyc, stb, we, stop, ack;
    logic lane, guard, func, dsp;
    logic [3:0] sel;
    int dsp_n;
    logic [7:0] adr, dat, rdat, sig;
    logic [15:0] angle;
    logic [15:0] exp_q[$];
    logic [7:0] cfg [0:31];
    int mismatches, check_count;
    otp_signature_burn_verify #(.BURN_CYC(CN), .REFRESH_CYC(CN)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
        .wb_dat_o(rdat), .wb_ack_o(ack), .angle_i(angle), .dsp_reset_o(dsp), .guard_band_o(guard),
        .functional_mode_o(func));
    magnet_model #(.POS_A(PA), .POS_B(PB)) mag (.clk_i(clk_i), .stop_i(stop), .angle_o(angle));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value at %0t: read %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [15:0] e);
        int n;
        if (!w) exp_q.push_back(e);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= {3'b000, lane};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            mismatches++;
            stop_test();
        end
    endtask : bus
    function automatic logic [7:0] misr();
        logic [7:0] m;
        m = 8'h00;
        for (int i = 2; i < 30; i++) begin
            m = {m[6:0], 1'b0} ^ cfg[i] ^ (m[7] ? SIG_POLY : 8'h00);
        end
        return m;
    endfunction : misr
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            chk(rdat & exp_q[0][15:8], exp_q[0][7:0]);
            void'(exp_q.pop_front());
        end
    end
    always @(posedge clk_i) begin
        if (dsp === 1'b1) dsp_n++;
    end
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        {rst_i, cyc, stb, we, stop, adr, dat} = {1'b1, 4'h0, 16'h0000};
        sel = 4'h0;
        lane = 1'b1;
        void'($urandom(26609));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b1, ADDR_CTRL, CTRL_DSP_RESET, 16'h0000);
        for (int p = 0; p < 2; p++) begin
            stop <= p[0];
            repeat (CN + 10) @(posedge clk_i);
            bus(1'b0, ADDR_ANGLE_LO, 8'h00, {8'hff, p[0] ? PB[7:0] : PA[7:0]});
            bus(1'b0, ADDR_ANGLE_HI, 8'h00, {8'hff, p[0] ? PB[15:8] : PA[15:8]});
        end
        chk(8'(dsp_n), 8'h01);
        for (int i = 2; i < 30; i++) cfg[i] = 8'($urandom);
        cfg[29][LOCK_BIT] = 1'b1;
        sig = misr();
        cfg[30] = sig;
        for (int i = 2; i < 31; i++) bus(1'b1, 8'(i), cfg[i], 16'h0000);
        for (int i = 2; i < 31; i++) bus(1'b0, 8'(i), 8'h00, {8'hff, cfg[i]});
        lane = 1'b0;
        bus(1'b1, 8'h0a, ~cfg[10], 16'h0000);
        lane = 1'b1;
        bus(1'b0, 8'h0a, 8'h00, {8'hff, cfg[10]});
        bus(1'b0, 8'h80, 8'h00, 16'hff00);
        bus(1'b1, ADDR_KEY1, KEY1_VAL, 16'h0000);
        bus(1'b1, ADDR_KEY2, 8'h00, 16'h0000);
        bus(1'b1, ADDR_KEY2, KEY2_VAL, 16'h0000);
        bus(1'b0, ADDR_STATUS, 8'h00, 16'h0b01);
        bus(1'b1, ADDR_KEY1, KEY1_VAL, 16'h0000);
        bus(1'b1, ADDR_KEY2, KEY2_VAL, 16'h0000);
        bus(1'b0, ADDR_STATUS, 8'h00, 16'h0202);
        bus(1'b1, ADDR_SIGNATURE, ~sig, 16'h0000);
        repeat (CN + 10) @(posedge clk_i);
        bus(1'b0, ADDR_STATUS, 8'h00, 16'h0b09);
        bus(1'b0, ADDR_SIG_CALC, 8'h00, {8'hff, sig});
        for (int t = 0; t < 2; t++) begin
            bus(1'b1, ADDR_SIGNATURE, 8'h00, 16'h0000);
            bus(1'b1, ADDR_CTRL, t ? CTRL_NORMAL : CTRL_GUARD, 16'h0000);
            repeat (CN + 10) @(posedge clk_i);
            bus(1'b0, ADDR_SIGNATURE, 8'h00, {8'hff, sig});
            bus(1'b0, 8'h0a, 8'h00, {8'hff, cfg[10]});
            bus(1'b0, ADDR_STATUS, 8'h00, {8'h14, t ? 8'h10 : 8'h14});
            chk({7'h00, guard}, t ? 8'h00 : 8'h01);
        end
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b1, ADDR_KEY1, KEY1_VAL, 16'h0000);
        bus(1'b1, ADDR_KEY2, KEY2_VAL, 16'h0000);
        bus(1'b0, ADDR_STATUS, 8'h00, 16'h0300);
        bus(1'b0, ADDR_SIGNATURE, 8'h00, {8'hff, sig});
        chk({7'h00, func}, 8'h01);
        repeat (3) @(posedge clk_i);
        stop_test();
    end
endmodule : otp_signature_burn_verify_bench

// ---- tb/otp_signature_burn_verify_props.sv ----
module otp_signature_burn_verify_props
    import otp_burn_pkg::*;
#(
    parameter int unsigned BURN_CYC = BURN_CYCLES,
    parameter int unsigned REFRESH_CYC = REFRESH_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_ack_o,
    input wire logic dsp_reset_o,
    input wire logic guard_band_o,
    input wire logic functional_mode_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic ctl_w;
    logic dsp_w;
    assign ctl_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == ADDR_CTRL;
    assign dsp_w = ctl_w && wb_dat_i == CTRL_DSP_RESET;
    a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_no_stray_ack: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack without request");
    a_dsp_pulse_seen: assert property (dsp_w |-> ##[1:2] dsp_reset_o)
        else $error("dsp reset missing");
    a_dsp_pulse_single: assert property (dsp_reset_o |=> !dsp_reset_o)
        else $error("dsp reset too long");
    a_dsp_has_cause: assert property (dsp_reset_o |-> $past(dsp_w) || $past(dsp_w, 2))
        else $error("dsp reset without write");
    a_guard_set: assert property (ctl_w && wb_dat_i == CTRL_GUARD |-> ##[1:2] guard_band_o)
        else $error("guard not set");
    a_guard_clear: assert property (ctl_w && wb_dat_i == CTRL_NORMAL |-> ##[1:2] !guard_band_o)
        else $error("guard not cleared");
    a_guard_cause: assert property ($rose(guard_band_o) |-> $past(ctl_w) || $past(ctl_w, 2))
        else $error("guard without write");
    a_mode_at_reset: assert property ($changed(functional_mode_o) |-> $past(rst_i))
        else $error("mode changed outside reset");
endmodule : otp_signature_burn_verify_props

bind otp_signature_burn_verify otp_signature_burn_verify_props #(.BURN_CYC(BURN_CYC),
    .REFRESH_CYC(REFRESH_CYC)) u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .dsp_reset_o(dsp_reset_o),
    .guard_band_o(guard_band_o), .functional_mode_o(functional_mode_o));
